// *** src/fpg_params.svh ***
// Constants for the flash page and sector guard
`ifndef FPG_PARAMS_SVH
`define FPG_PARAMS_SVH

// Register-file addresses
`define FPG_ADDR_CTRL 12'hff8
`define FPG_ADDR_PAGE 12'hff9
`define FPG_ADDR_FREQH 12'hffa
`define FPG_ADDR_FREQL 12'hffb

// Reset values
`define FPG_PAGE_RST 8'h00
`define FPG_LOCK_RST 8'h00
`define FPG_FREQ_RST 16'h0000
`define FPG_RD_ZERO 8'h00

// Control keys
`define FPG_PROT_KEY 8'h5e

// Page select fields
`define FPG_INFO_BIT 7
`define FPG_PAGE_MSB 6
`define FPG_PAGE_LSB 0
`define FPG_INFO_PAGE 7'h7f

// Sector number within the page number
`define FPG_SECT_MSB 6
`define FPG_SECT_LSB 4

// Controller state codes
`define FPG_ST_LOCKED 6'h00
`define FPG_ST_UNLK1 6'h01
`define FPG_ST_UNLK2 6'h02
`define FPG_ST_OPEN 6'h03
`define FPG_ST_PROT 6'h04
`define FPG_ST_PROG_HI 3'h1
`define FPG_ST_PERASE_HI 3'h2
`define FPG_ST_MERASE_HI 3'h4

// Byte value left by an erase
`define FPG_ERASE_BYTE 8'hff
`define FPG_BYTE_ZERO 8'h00
`define FPG_PHASE_ONE 3'h1
`define FPG_PHASE_ZERO 3'h0

`endif

// *** src/fpg_pkg.sv ***
// Types shared by the flash page and sector guard modules
package fpg_pkg;
  `include "fpg_params.svh"

  // Controller sequencing states
  typedef enum logic [2:0] {
    FPG_LOCKED = 3'b000,
    FPG_UNLK1 = 3'b001,
    FPG_UNLK2 = 3'b010,
    FPG_OPEN = 3'b011,
    FPG_PROT = 3'b100,
    FPG_PROG = 3'b101,
    FPG_PERASE = 3'b110,
    FPG_MERASE = 3'b111
  } fpg_state_t;

  // Operation kinds handed to the array
  typedef enum logic [1:0] {
    FPG_CMD_NONE = 2'b00,
    FPG_CMD_PROG = 2'b01,
    FPG_CMD_PERASE = 2'b10,
    FPG_CMD_MERASE = 2'b11
  } fpg_cmd_t;

  // Status byte for a state and operation phase
  function automatic logic [7:0] fpg_status_code(input fpg_state_t st, input logic [2:0] phase);
    logic [5:0] code;
    code = `FPG_ST_LOCKED;
    unique case (st)
      FPG_LOCKED: code = `FPG_ST_LOCKED;
      FPG_UNLK1: code = `FPG_ST_UNLK1;
      FPG_UNLK2: code = `FPG_ST_UNLK2;
      FPG_OPEN: code = `FPG_ST_OPEN;
      FPG_PROT: code = `FPG_ST_PROT;
      FPG_PROG: code = {`FPG_ST_PROG_HI, phase};
      FPG_PERASE: code = {`FPG_ST_PERASE_HI, phase};
      FPG_MERASE: code = {`FPG_ST_MERASE_HI, phase};
    endcase
    return {2'b00, code};
  endfunction
endpackage

// *** src/fpg_guard_if.sv ***
// Interface between the sequencer and the protection check
`timescale 1ns/1ps
interface fpg_guard_if;
  import fpg_pkg::*;
  logic [7:0] lock_bits;
  logic [6:0] page;
  logic info;
  fpg_cmd_t kind;
  logic allow;
  modport ctrl (output lock_bits, page, info, kind, input allow);
  modport guard (input lock_bits, page, info, kind, output allow);
endinterface

// *** src/fpg_sector_check.sv ***
// Protection check of a requested operation against the sector locks
`timescale 1ns/1ps
module fpg_sector_check
  import fpg_pkg::*;
(
  // Request and verdict
  fpg_guard_if.guard g
);
  `include "fpg_params.svh"

  // Sector addressed by the selected page
  wire [2:0] sect_idx = g.page[`FPG_SECT_MSB:`FPG_SECT_LSB];
  wire sect_locked = g.lock_bits[sect_idx];
  wire any_locked = |g.lock_bits;

  // Mass erase needs every sector free, main page work only its own, info page work none
  assign g.allow = (g.kind == FPG_CMD_NONE) ? 1'b0 :
                   (g.kind == FPG_CMD_MERASE) ? ~any_locked :
                   g.info ? 1'b1 : ~sect_locked;
endmodule

// *** src/fpg_flash_guard.sv ***
// Flash page select, sector lock and controller state registers
//
// Overview of operation
// - State codes track unlock steps and protect select
// - Running operation shows program or erase pattern
// - Array has 128 pages of 512 bytes
// - Page erase fills selected page with FFH
// - Page number drives address bits 15 to 9
// - Info select maps area at FE00H to FFFFH
// - Shared address reaches lock when protect selected
// - Lock register exposed only after 5EH write
// - Lock writes can only set bits
// - Locked sector refuses program and erase
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module fpg_flash_guard
  import fpg_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY1 = 8'h11,
  parameter logic [7:0] UNLOCK_KEY2 = 8'h22,
  parameter logic [7:0] PERASE_KEY = 8'h33,
  parameter logic [7:0] MERASE_KEY = 8'h44,
  parameter int PAGE_COUNT = 128,
  parameter int PAGE_BYTES = 512
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [7:0] o_rd_data,
  // Program request from the core
  input wire logic i_prog_req,
  input wire logic [8:0] i_prog_offset,
  input wire logic [7:0] i_prog_data,
  // Flash array side
  output logic o_flash_start,
  output logic [1:0] o_flash_cmd,
  output logic [15:0] o_flash_addr,
  output logic [7:0] o_flash_data,
  output logic o_info_sel,
  input wire logic i_flash_done,
  // Status
  output logic o_refused,
  output logic o_busy,
  output logic [7:0] o_sector_lock
);
  `include "fpg_params.svh"

  localparam int PAGE_AW = $clog2(PAGE_COUNT);
  localparam int BYTE_AW = $clog2(PAGE_BYTES);

  // Registers
  fpg_state_t state_reg, state_next;
  logic [7:0] page_select_reg, page_select_next;
  logic [7:0] sector_lock_reg, sector_lock_next;
  logic [15:0] clock_khz_value_reg, clock_khz_value_next;
  logic [2:0] phase_reg, phase_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic start_reg, start_next;
  logic [1:0] cmd_reg, cmd_next;
  logic [15:0] faddr_reg, faddr_next;
  logic [7:0] fdata_reg, fdata_next;
  logic info_reg, info_next;
  logic refused_reg, refused_next;

  // Protection check
  fpg_guard_if gif ();
  fpg_cmd_t req_kind;

  fpg_sector_check u_check (
    .g (gif.guard)
  );

  // Address decode
  wire hit_ctrl = (i_addr == `FPG_ADDR_CTRL);
  wire hit_page = (i_addr == `FPG_ADDR_PAGE);
  wire hit_freqh = (i_addr == `FPG_ADDR_FREQH);
  wire hit_freql = (i_addr == `FPG_ADDR_FREQL);
  wire wr_ctrl = i_wr_stb & hit_ctrl;
  wire wr_shared = i_wr_stb & hit_page;
  wire prot_view = (state_reg == FPG_PROT);
  wire wr_page = wr_shared & ~prot_view;
  wire wr_lock = wr_shared & prot_view;
  wire wr_freqh = i_wr_stb & hit_freqh;
  wire wr_freql = i_wr_stb & hit_freql;
  wire is_open = (state_reg == FPG_OPEN);
  wire is_op = (state_reg == FPG_PROG) | (state_reg == FPG_PERASE) | (state_reg == FPG_MERASE);
  wire freq_set = (clock_khz_value_reg != `FPG_FREQ_RST);

  // Page and info fields
  wire info_area_select = page_select_reg[`FPG_INFO_BIT];
  wire [PAGE_AW-1:0] page_num = page_select_reg[`FPG_PAGE_MSB:`FPG_PAGE_LSB];
  wire [PAGE_AW-1:0] target_page = info_area_select ? `FPG_INFO_PAGE : page_num;

  // Operation request decode
  wire want_perase = wr_ctrl & is_open & (i_wr_data == PERASE_KEY);
  wire want_merase = wr_ctrl & is_open & (i_wr_data == MERASE_KEY);
  wire want_prog = i_prog_req & is_open & ~wr_ctrl;
  assign req_kind = want_merase ? FPG_CMD_MERASE :
                    want_perase ? FPG_CMD_PERASE :
                    want_prog ? FPG_CMD_PROG : FPG_CMD_NONE;
  wire req_any = want_merase | want_perase | want_prog;
  wire req_ok = gif.allow & freq_set;

  // Guard inputs
  assign gif.lock_bits = sector_lock_reg;
  assign gif.page = target_page;
  assign gif.info = info_area_select;
  assign gif.kind = req_kind;

  // Read data selection
  wire [7:0] status_byte = fpg_status_code(state_reg, phase_reg);
  wire [7:0] shared_rd = prot_view ? sector_lock_reg : page_select_reg;
  wire [7:0] rd_sel = hit_ctrl ? status_byte :
                      hit_page ? shared_rd :
                      hit_freqh ? clock_khz_value_reg[15:8] :
                      hit_freql ? clock_khz_value_reg[7:0] : `FPG_RD_ZERO;

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    unique case (state_reg)
      FPG_LOCKED: begin
        if (wr_ctrl && i_wr_data == UNLOCK_KEY1) begin
          state_next = FPG_UNLK1;
        end else if (wr_ctrl && i_wr_data == `FPG_PROT_KEY) begin
          state_next = FPG_PROT;
        end
      end
      FPG_UNLK1: begin
        if (wr_ctrl) begin
          state_next = (i_wr_data == UNLOCK_KEY2) ? FPG_UNLK2 : FPG_LOCKED;
        end
      end
      FPG_UNLK2: begin
        if (wr_ctrl) begin
          state_next = FPG_LOCKED;
        end else if (wr_page) begin
          state_next = FPG_OPEN;
        end
      end
      FPG_OPEN: begin
        if (req_any && req_ok) begin
          phase_next = `FPG_PHASE_ZERO;
          unique case (req_kind)
            FPG_CMD_PROG: state_next = FPG_PROG;
            FPG_CMD_PERASE: state_next = FPG_PERASE;
            FPG_CMD_MERASE: state_next = FPG_MERASE;
            FPG_CMD_NONE: state_next = FPG_OPEN;
          endcase
        end else if (req_any) begin
          state_next = FPG_LOCKED;
        end else if (wr_ctrl) begin
          state_next = FPG_LOCKED;
        end
      end
      FPG_PROT: begin
        if (wr_ctrl) begin
          state_next = FPG_LOCKED;
        end
      end
      FPG_PROG, FPG_PERASE, FPG_MERASE: begin
        phase_next = phase_reg + `FPG_PHASE_ONE;
        if (i_flash_done) begin
          state_next = (state_reg == FPG_PROG) ? FPG_OPEN : FPG_LOCKED;
        end
      end
    endcase
  end

  // Register file next values
  always_comb begin
    page_select_next = page_select_reg;
    sector_lock_next = sector_lock_reg;
    clock_khz_value_next = clock_khz_value_reg;
    if (wr_page && !is_op) begin
      page_select_next = i_wr_data;
    end
    if (wr_lock) begin
      sector_lock_next = sector_lock_reg | i_wr_data;
    end
    if (wr_freqh && !is_op) begin
      clock_khz_value_next = {i_wr_data, clock_khz_value_reg[7:0]};
    end
    if (wr_freql && !is_op) begin
      clock_khz_value_next = {clock_khz_value_reg[15:8], i_wr_data};
    end
  end

  // Array command launch
  always_comb begin
    start_next = 1'b0;
    cmd_next = cmd_reg;
    faddr_next = faddr_reg;
    fdata_next = fdata_reg;
    info_next = info_reg;
    refused_next = req_any & ~req_ok;
    if (req_any && req_ok) begin
      start_next = 1'b1;
      cmd_next = req_kind;
      info_next = info_area_select;
      if (req_kind == FPG_CMD_PROG) begin
        faddr_next = {target_page, i_prog_offset[BYTE_AW-1:0]};
        fdata_next = i_prog_data;
      end else if (req_kind == FPG_CMD_PERASE) begin
        faddr_next = {target_page, {BYTE_AW{1'b0}}};
        fdata_next = `FPG_ERASE_BYTE;
      end else begin
        faddr_next = '0;
        fdata_next = `FPG_ERASE_BYTE;
      end
    end
  end

  // Read data one cycle after the strobe
  assign rd_data_next = i_rd_stb ? rd_sel : `FPG_RD_ZERO;

  // Sequencer state
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= FPG_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  // Operation phase counter
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      phase_reg <= `FPG_PHASE_ZERO;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Page select register
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      page_select_reg <= `FPG_PAGE_RST;
    end else begin
      page_select_reg <= page_select_next;
    end
  end

  // Sector lock register, cleared by reset alone
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sector_lock_reg <= `FPG_LOCK_RST;
    end else begin
      sector_lock_reg <= sector_lock_next;
    end
  end

  // Clock frequency value
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      clock_khz_value_reg <= `FPG_FREQ_RST;
    end else begin
      clock_khz_value_reg <= clock_khz_value_next;
    end
  end

  // Read data register
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rd_data_reg <= `FPG_RD_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Launch and refusal pulses
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      start_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
      refused_reg <= refused_next;
    end
  end

  // Array command, address and data
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cmd_reg <= FPG_CMD_NONE;
      faddr_reg <= '0;
      fdata_reg <= `FPG_BYTE_ZERO;
      info_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      faddr_reg <= faddr_next;
      fdata_reg <= fdata_next;
      info_reg <= info_next;
    end
  end

  // Outputs
  assign o_rd_data = rd_data_reg;
  assign o_flash_start = start_reg;
  assign o_flash_cmd = cmd_reg;
  assign o_flash_addr = faddr_reg;
  assign o_flash_data = fdata_reg;
  assign o_info_sel = info_reg;
  assign o_refused = refused_reg;
  assign o_busy = is_op;
  assign o_sector_lock = sector_lock_reg;
endmodule

// *** verif/fpg_flash_model.sv ***
// Flash array model that answers a launched operation with a done pulse
`timescale 1ns/1ps
module fpg_flash_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Launch and pace
  input wire logic i_start,
  input wire logic i_slow,
  // Completion
  output logic o_done
);
  logic [3:0] cnt_reg;
  logic run_reg;
  // Counts down a prompt or slow delay, then pulses done once
  always_ff @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    if (i_reset) begin
      run_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (i_start) begin
      run_reg <= 1'b1;
      cnt_reg <= i_slow ? 4'h9 : 4'h1;
    end else if (run_reg && cnt_reg == 4'h0) begin
      o_done <= 1'b1;
      run_reg <= 1'b0;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

// *** verif/fpg_flash_guard_sva.sv ***
// Port checker of the flash page and sector guard
`timescale 1ns/1ps
module fpg_flash_guard_chk (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register port and requests
  input wire logic [11:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] o_rd_data,
  input wire logic [8:0] i_prog_offset,
  input wire logic [7:0] i_prog_data,
  // Array side and status
  input wire logic o_flash_start,
  input wire logic [1:0] o_flash_cmd,
  input wire logic [15:0] o_flash_addr,
  input wire logic [7:0] o_flash_data,
  input wire logic o_info_sel,
  input wire logic i_flash_done,
  input wire logic o_refused,
  input wire logic o_busy,
  input wire logic [7:0] o_sector_lock
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  start_busy_a: assert property (o_flash_start |-> o_busy && !o_refused)
    else $error("launch without busy or with refusal");
  busy_end_a: assert property (o_busy && i_flash_done |=> !o_busy)
    else $error("busy after done");
  rd_idle_a: assert property (!i_rd_stb |=> o_rd_data == 8'h00)
    else $error("read data outside read slot");
  busy_status_a: assert property (i_rd_stb && i_addr == 12'hff8 && o_busy |=>
    o_rd_data[7:6] == 2'b00 && o_rd_data[5:3] inside {3'h1, 3'h2, 3'h4}) else $error("bad busy status");
  lock_set_only_a: assert property (($past(o_sector_lock) & ~o_sector_lock) == 8'h00)
    else $error("lock bit cleared");
  lock_cause_a: assert property ($changed(o_sector_lock) |-> $past(i_wr_stb && i_addr == 12'hff9))
    else $error("lock changed without write");
  erase_data_a: assert property (o_flash_start && o_flash_cmd != 2'h1 |-> o_flash_data == 8'hff)
    else $error("erase byte wrong");
  erase_page_a: assert property (o_flash_start && o_flash_cmd == 2'h2 |-> o_flash_addr[8:0] == 9'h000)
    else $error("page erase offset wrong");
  info_page_a: assert property (o_flash_start && o_info_sel |-> o_flash_addr[15:9] == 7'h7f)
    else $error("info area address wrong");
  prog_addr_a: assert property (o_flash_start && o_flash_cmd == 2'h1 |->
    o_flash_addr[8:0] == $past(i_prog_offset) && o_flash_data == $past(i_prog_data)) else $error("program target");
  // Main scenarios seen
  cover property (o_flash_start);
  cover property (o_refused);
  cover property ($changed(o_sector_lock));
endmodule

// *** verif/tb_fpg_flash_guard.sv ***
// Testbench of the flash page and sector guard
`timescale 1ns/1ps
module tb_fpg_flash_guard;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0;
  logic i_prog_req = 1'b0;
  logic slow = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wr_data = 8'h00;
  logic [7:0] i_prog_data = 8'h00;
  logic [8:0] i_prog_offset = 9'h000;
  logic [7:0] o_rd_data, o_flash_data, o_sector_lock;
  logic [1:0] o_flash_cmd;
  logic [15:0] o_flash_addr;
  logic o_flash_start, o_info_sel, i_flash_done, o_refused, o_busy;
  int n_fail = 0;
  int n_checks = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  fpg_flash_guard uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_prog_req(i_prog_req),
    .i_prog_offset(i_prog_offset), .i_prog_data(i_prog_data), .o_flash_start(o_flash_start),
    .o_flash_cmd(o_flash_cmd), .o_flash_addr(o_flash_addr), .o_flash_data(o_flash_data), .o_info_sel(o_info_sel),
    .i_flash_done(i_flash_done), .o_refused(o_refused), .o_busy(o_busy), .o_sector_lock(o_sector_lock));
  fpg_flash_model fm (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_start(o_flash_start), .i_slow(slow),
    .o_done(i_flash_done));
  // Compares one value
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write, one strobe cycle
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b0;
    #1;
  endtask
  // Register read, data checked in the following cycle
  task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b0;
    #1;
    chk({8'h00, o_rd_data & m}, {8'h00, e});
  endtask
  // Launched operation seen at the array side
  task op(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d);
    chk({15'h0000, o_flash_start}, 16'h0001);
    chk({14'h0000, o_flash_cmd}, {14'h0000, c});
    chk(o_flash_addr, a);
    chk({8'h00, o_flash_data}, {8'h00, d});
  endtask
  task unlock(input logic [7:0] pg);
    wr(12'hff8, 8'h11);
    wr(12'hff8, 8'h22);
    wr(12'hff9, pg);
  endtask
  task prog(input logic [8:0] off, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_prog_req <= 1'b1;
    i_prog_offset <= off;
    i_prog_data <= d;
    @(posedge i_sys_clk);
    i_prog_req <= 1'b0;
    #1;
  endtask
  // Bounded wait for the operation to finish
  task idle();
    int i;
    for (i = 0; i < 40 && o_busy !== 1'b0; i++) @(posedge i_sys_clk);
    if (i == 40) begin
      n_fail++;
      $display("mismatch at %0t: busy never fell", $time);
      complete_run();
    end else begin
      #1;
    end
  endtask
  task complete_run();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rd(12'hff8, 8'h00, 8'hff);
    rd(12'h123, 8'h00, 8'hff);
    wr(12'hff8, 8'h11);
    rd(12'hff8, 8'h01, 8'hff);
    wr(12'hff8, 8'h22);
    rd(12'hff8, 8'h02, 8'hff);
    wr(12'hff9, 8'h05);
    rd(12'hff8, 8'h03, 8'hff);
    rd(12'hff9, 8'h05, 8'hff);
    wr(12'hff8, 8'h33);
    chk({15'h0000, o_refused}, 16'h0001);
    wr(12'hff8, 8'h11);
    wr(12'hff8, 8'h55);
    rd(12'hff8, 8'h00, 8'hff);
    wr(12'hffa, 8'h4e);
    wr(12'hffb, 8'h20);
    slow = 1'b1;
    unlock(8'h05);
    wr(12'hff8, 8'h33);
    op(2'h2, 16'h0a00, 8'hff);
    rd(12'hff8, 8'h10, 8'hf8);
    idle();
    rd(12'hff8, 8'h00, 8'hff);
    unlock(8'h05);
    prog(9'h1a5, 8'h3c);
    op(2'h1, 16'h0ba5, 8'h3c);
    rd(12'hff8, 8'h08, 8'hf8);
    idle();
    rd(12'hff8, 8'h03, 8'hff);
    slow = 1'b0;
    wr(12'hff8, 8'h00);
    unlock(8'h80);
    wr(12'hff8, 8'h33);
    op(2'h2, 16'hfe00, 8'hff);
    chk({15'h0000, o_info_sel}, 16'h0001);
    idle();
    unlock(8'h05);
    wr(12'hff8, 8'h44);
    op(2'h3, 16'h0000, 8'hff);
    idle();
    wr(12'hff8, 8'h5e);
    rd(12'hff8, 8'h04, 8'hff);
    wr(12'hff9, 8'h04);
    rd(12'hff9, 8'h04, 8'hff);
    wr(12'hff9, 8'h01);
    wr(12'hff9, 8'h00);
    rd(12'hff9, 8'h05, 8'hff);
    wr(12'hff8, 8'h00);
    rd(12'hff9, 8'h05, 8'hff);
    unlock(8'h25);
    wr(12'hff8, 8'h33);
    chk({15'h0000, o_refused}, 16'h0001);
    chk({15'h0000, o_flash_start}, 16'h0000);
    unlock(8'h15);
    wr(12'hff8, 8'h33);
    op(2'h2, 16'h2a00, 8'hff);
    idle();
    unlock(8'h15);
    wr(12'hff8, 8'h44);
    chk({15'h0000, o_refused}, 16'h0001);
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1;
    chk({8'h00, o_sector_lock}, 16'h0000);
    rd(12'hff9, 8'h00, 8'hff);
    complete_run();
  end
endmodule
bind fpg_flash_guard fpg_flash_guard_chk chk_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
  .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_prog_offset(i_prog_offset),
  .i_prog_data(i_prog_data), .o_flash_start(o_flash_start), .o_flash_cmd(o_flash_cmd), .o_flash_addr(o_flash_addr),
  .o_flash_data(o_flash_data), .o_info_sel(o_info_sel), .i_flash_done(i_flash_done), .o_refused(o_refused),
  .o_busy(o_busy), .o_sector_lock(o_sector_lock));
